// ==== core/guard_pkg.sv ====
// Purpose: shared constants and types for the sector guard map command block
// Assumes: core clock of 100 MHz; link clock supplied by the host during frames
// Notes: the map and its staging buffer are volatile models of nonvolatile cells
package guard_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int MAP_BYTES = 32;
  localparam int PTR_W = 5;
  localparam int FLAG_W = 33;
  localparam logic [7:0] BYTE_SHIPPED = 8'h00;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam int SUB0A_HI = 7;
  localparam int SUB0A_LO = 6;
  localparam int SUB0B_HI = 5;
  localparam int SUB0B_LO = 4;
  localparam logic [31:0] CMD_MAP_ERASE = 32'h3D2A7FCF;
  localparam logic [31:0] CMD_MAP_PROGRAM = 32'h3D2A7FFC;
  localparam logic [7:0] CMD_MAP_READ = 8'h32;
  localparam logic [3:0] DUMMY_SERIAL = 4'h3;
  localparam logic [3:0] DUMMY_PARALLEL = 4'h7;
  localparam int MAP_ERASE_TIME_US = 50;
  localparam int MAP_PROGRAM_TIME_US = 50;
  localparam int ERASE_CYCLES = MAP_ERASE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int PROGRAM_CYCLES = MAP_PROGRAM_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_PROG_DATA = 3'b010,
    ST_ERASE_PEND = 3'b011,
    ST_IGNORE = 3'b100,
    ST_ERASE = 3'b101,
    ST_PROGRAM = 3'b110
  } core_state_type;
endpackage

// ==== core/guard_link_if.sv ====
// Purpose: byte carrier between the link-clock front end and the core
// Assumes: rx_byte is stable whenever rx_tog may be sampled
// Notes: tx_byte is quasi-static; the core settles it long before it is loaded
`timescale 1ns/1ps
`default_nettype none
interface guard_link_if;
  logic [7:0] rx_byte;
  logic rx_tog;
  logic par_mode;
  logic [7:0] tx_byte;
  modport link (output rx_byte, output rx_tog, output par_mode, input tx_byte);
  modport core (input rx_byte, input rx_tog, input par_mode, output tx_byte);
endinterface
`default_nettype wire

// ==== core/guard_map_mem.sv ====
// Purpose: small byte memory with a registered read port
// Assumes: one write and one read per clock
// Notes: reset loads the init value into every cell
`timescale 1ns/1ps
`default_nettype none
module guard_map_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter logic [7:0] INIT = 8'h00
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] rdata;
  } mem_state_type;
  mem_state_type s, n;
  always_comb begin
    n = s;
    if (we_in) begin
      n.cells[waddr_in] = wdata_in;
    end
    n.rdata = s.cells[raddr_in];
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= {DEPTH + 1{INIT[WIDTH-1:0]}};
    end else begin
      s <= n;
    end
  end
  assign rdata_out = s.rdata;
endmodule
`default_nettype wire

// ==== core/guard_link.sv ====
// Purpose: link-clock front end; assembles bytes and streams read data out
// Assumes: port select static during a frame; pins change away from rising edges
// Notes: frame state is cleared by deselect, since the link clock stops between frames
`timescale 1ns/1ps
`default_nettype none
module guard_link
  import guard_pkg::*;
(
  // Link clock and pins
  input wire logic link_clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic port_sel_in,
  input wire logic [7:0] par_in,
  // Driven pins
  output logic so_out,
  output logic so_oe_out,
  output logic [7:0] par_out,
  output logic par_oe_out,
  // Core side
  guard_link_if.link lk
);
  typedef struct packed {
    logic [6:0] sh;
    logic [2:0] bits;
    logic [3:0] nbytes;
    logic is_read;
    logic [7:0] out_sh;
    logic so;
    logic so_oe;
    logic [7:0] pout;
    logic poe;
  } frame_type;
  typedef struct packed {
    logic [7:0] rx_byte;
    logic rx_tog;
    logic par_mode;
  } word_type;
  frame_type f, fn;
  word_type w, wn;
  logic frame_rst_n;
  logic done;
  logic [7:0] got;
  logic [3:0] nb_inc;
  logic [3:0] dummies;
  // Deselect floats the outputs at once, clock or no clock
  assign frame_rst_n = rst_n_in & ~cs_n_in;
  always_comb begin
    fn = f;
    wn = w;
    got = port_sel_in ? par_in : {f.sh, si_in};
    done = port_sel_in | (f.bits == 3'h7);
    nb_inc = (f.nbytes == 4'hF) ? f.nbytes : f.nbytes + 4'h1;
    dummies = port_sel_in ? DUMMY_PARALLEL : DUMMY_SERIAL;
    fn.bits = f.bits + 3'h1;
    fn.sh = {f.sh[5:0], si_in};
    wn.par_mode = port_sel_in;
    if (f.so_oe) begin
      fn.so = f.out_sh[6];
      fn.out_sh = {f.out_sh[6:0], 1'b0};
    end
    if (done) begin
      fn.bits = 3'h0;
      fn.nbytes = nb_inc;
      wn.rx_byte = got;
      wn.rx_tog = ~w.rx_tog;
      if (f.nbytes == 4'h0) begin
        fn.is_read = (got == CMD_MAP_READ);
      end
      if (f.is_read && nb_inc >= dummies + 4'h1) begin
        fn.out_sh = lk.tx_byte;
        fn.so = lk.tx_byte[7];
        fn.so_oe = ~port_sel_in;
        fn.pout = lk.tx_byte;
        fn.poe = port_sel_in;
      end
    end
  end
  always_ff @(posedge link_clk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f <= '0;
    end else begin
      f <= fn;
    end
  end
  // Toggle survives deselect so the core never sees a false byte
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w <= '0;
    end else begin
      w <= wn;
    end
  end
  assign lk.rx_byte = w.rx_byte;
  assign lk.rx_tog = w.rx_tog;
  assign lk.par_mode = w.par_mode;
  assign so_out = f.so;
  assign so_oe_out = f.so_oe;
  assign par_out = f.pout;
  assign par_oe_out = f.poe;
endmodule
`default_nettype wire

// ==== core/sector_guard_map.sv ====
// Purpose: command handling for the sector guard map (erase, program, read)
// Assumes: host clocks the link only while selected; program and erase
//   are not mixed with other commands during a self-timed cycle
// Notes: the block outputs drive the array's program/erase gate
`timescale 1ns/1ps
`default_nettype none
module sector_guard_map
  import guard_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_CYCLES,
  parameter int unsigned PROGRAM_CYC = PROGRAM_CYCLES
) (
  // Core clock and reset
  input wire logic MCLK_IN,
  input wire logic NRST_IN,

  // Link pins
  input wire logic LINK_CLK_IN,
  input wire logic CS_N_IN,
  input wire logic SI_IN,
  input wire logic PORT_SEL_IN,
  input wire logic [7:0] PARALLEL_DATA_LINES_IN,
  output logic SO_OUT,
  output logic SO_OE_OUT,
  output logic [7:0] PARALLEL_DATA_LINES_OUT,
  output logic PARALLEL_DATA_LINES_OE_OUT,

  // Protection controls
  input wire logic PROT_EN_IN,
  input wire logic WP_N_IN,

  // Status and gate
  output logic MAP_BUSY_OUT,
  output logic [FLAG_W-1:0] BLOCK_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  typedef struct packed {
    core_state_type state;
    logic [3:0] cs_sync;
    logic [1:0] wp_sync;
    logic [2:0] tog_sync;
    logic [23:0] opc;
    logic [3:0] nbytes;
    logic [PTR_W-1:0] ptr;
    logic [5:0] step;
    logic [31:0] timer;
    logic [FLAG_W-1:0] flags;
    logic busy;
    logic [FLAG_W-1:0] block;
  } core_type;

  core_type s, n;
  guard_link_if lk ();

  logic ev;
  logic cs_rise;
  logic [3:0] nb_inc;
  logic [3:0] dummies;
  logic map_we;
  logic [PTR_W-1:0] map_waddr;
  logic [7:0] map_wdata;
  logic [7:0] map_rdata;
  logic buf_we;
  logic [7:0] buf_rdata;

  // ----------------------------------------------------------------
  // Decode of one map byte into the sector flags
  // ----------------------------------------------------------------

  function automatic logic [FLAG_W-1:0] mark(input logic [FLAG_W-1:0] fl,
                                            input logic [PTR_W-1:0] addr,
                                            input logic [7:0] d);
    logic [FLAG_W-1:0] r;
    r = fl;
    if (addr == 5'h00) begin
      r[0] = &d[SUB0A_HI:SUB0A_LO];
      r[1] = &d[SUB0B_HI:SUB0B_LO];
    end else begin
      r[32'(addr) + 1] = (d == BYTE_ERASED);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  always_comb begin
    n = s;
    // Byte events use one sync stage less than deselect, so a last
    // byte is always taken before the frame end is seen
    ev = s.tog_sync[2] ^ s.tog_sync[1];
    cs_rise = s.cs_sync[2] & ~s.cs_sync[3];
    nb_inc = (s.nbytes == 4'hF) ? s.nbytes : s.nbytes + 4'h1;
    dummies = lk.par_mode ? DUMMY_PARALLEL : DUMMY_SERIAL;
    map_we = 1'b0;
    map_waddr = s.step[PTR_W-1:0];
    map_wdata = BYTE_ERASED;
    buf_we = 1'b0;
    n.cs_sync = {s.cs_sync[2:0], CS_N_IN};
    n.wp_sync = {s.wp_sync[0], WP_N_IN};
    n.tog_sync = {s.tog_sync[1:0], lk.rx_tog};
    n.block = s.flags & {FLAG_W{PROT_EN_IN | ~s.wp_sync[1]}};
    case (s.state)
      ST_IDLE: begin
        if (cs_rise) begin
          n.nbytes = 4'h0;
        end else if (ev) begin
          n.nbytes = nb_inc;
          if (s.nbytes == 4'h0 && lk.rx_byte == CMD_MAP_READ) begin
            n.state = ST_READ;
            n.ptr = '0;
          end else if (s.nbytes < 4'h3) begin
            n.opc = {s.opc[15:0], lk.rx_byte};
          end else if ({s.opc, lk.rx_byte} == CMD_MAP_ERASE) begin
            n.state = ST_ERASE_PEND;
          end else if ({s.opc, lk.rx_byte} == CMD_MAP_PROGRAM) begin
            n.state = ST_PROG_DATA;
            n.ptr = '0;
          end else begin
            n.state = ST_IGNORE;
          end
        end
      end
      ST_READ: begin
        if (cs_rise) begin
          n.state = ST_IDLE;
          n.nbytes = 4'h0;
        end else if (ev) begin
          n.nbytes = nb_inc;
          // Fetch one byte ahead of the link so the next load is ready
          if (nb_inc >= dummies + 4'h1) begin
            n.ptr = s.ptr + 5'h01;
          end
        end
      end
      ST_PROG_DATA: begin
        if (cs_rise) begin
          n.state = ST_PROGRAM;
          n.busy = 1'b1;
          n.step = 6'h00;
          n.timer = 32'h0;
        end else if (ev) begin
          buf_we = 1'b1;
          n.ptr = s.ptr + 5'h01;
        end
      end
      ST_ERASE_PEND: begin
        if (cs_rise) begin
          n.state = ST_ERASE;
          n.busy = 1'b1;
          n.step = 6'h00;
          n.timer = 32'h0;
        end
      end
      ST_IGNORE: begin
        if (cs_rise) begin
          n.state = ST_IDLE;
          n.nbytes = 4'h0;
        end
      end
      ST_ERASE: begin
        if (s.step < 6'h20) begin
          map_we = 1'b1;
          n.step = s.step + 6'h01;
        end
        n.timer = s.timer + 32'h1;
        if (s.timer == 32'(ERASE_CYC - 1)) begin
          // A frame still open here began inside busy, so it is dropped whole
          n.state = s.cs_sync[2] ? ST_IDLE : ST_IGNORE;
          n.busy = 1'b0;
          n.nbytes = 4'h0;
        end
      end
      ST_PROGRAM: begin
        // Buffer read is registered, so write lags the read by one
        if (s.step != 6'h00 && s.step <= 6'h20) begin
          map_we = 1'b1;
          map_waddr = 5'(s.step - 6'h01);
          map_wdata = buf_rdata;
        end
        if (s.step <= 6'h20) begin
          n.step = s.step + 6'h01;
        end
        n.timer = s.timer + 32'h1;
        if (s.timer == 32'(PROGRAM_CYC - 1)) begin
          n.state = s.cs_sync[2] ? ST_IDLE : ST_IGNORE;
          n.busy = 1'b0;
          n.nbytes = 4'h0;
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
    if (map_we) begin
      n.flags = mark(s.flags, map_waddr, map_wdata);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s <= '{state: ST_IDLE, cs_sync: 4'hF, wp_sync: 2'h3, default: '0};
    end else begin
      s <= n;
    end
  end

  assign MAP_BUSY_OUT = s.busy;
  assign BLOCK_OUT = s.block;
  assign lk.tx_byte = map_rdata;

  // ----------------------------------------------------------------
  // Map cells and staging buffer
  // ----------------------------------------------------------------

  guard_map_mem #(
    .WIDTH(8),
    .DEPTH(MAP_BYTES),
    .AW(PTR_W),
    .INIT(BYTE_SHIPPED)
  ) map_mem (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .we_in(map_we),
    .waddr_in(map_waddr),
    .wdata_in(map_wdata),
    .raddr_in(s.ptr),
    .rdata_out(map_rdata)
  );

  // Only the first 32 buffer bytes are modelled; that is all the map uses
  guard_map_mem #(
    .WIDTH(8),
    .DEPTH(MAP_BYTES),
    .AW(PTR_W),
    .INIT(BYTE_SHIPPED)
  ) stage_buf (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .we_in(buf_we),
    .waddr_in(s.ptr),
    .wdata_in(lk.rx_byte),
    .raddr_in(s.step[PTR_W-1:0]),
    .rdata_out(buf_rdata)
  );

  // ----------------------------------------------------------------
  // Link front end
  // ----------------------------------------------------------------

  guard_link link_end (
    .link_clk_in(LINK_CLK_IN),
    .rst_n_in(NRST_IN),
    .cs_n_in(CS_N_IN),
    .si_in(SI_IN),
    .port_sel_in(PORT_SEL_IN),
    .par_in(PARALLEL_DATA_LINES_IN),
    .so_out(SO_OUT),
    .so_oe_out(SO_OE_OUT),
    .par_out(PARALLEL_DATA_LINES_OUT),
    .par_oe_out(PARALLEL_DATA_LINES_OE_OUT),
    .lk(lk.link)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  AST_ERASE_START: assert property (
    s.state == ST_ERASE_PEND && cs_rise |=> s.state == ST_ERASE && s.busy)
    else $error("map erase did not start on deselect");

  AST_BUSY_HOLD: assert property (
    $rose(s.busy) |-> MAP_BUSY_OUT [*8])
    else $error("busy dropped early");

  AST_ERASE_FILL: assert property (
    s.state == ST_ERASE && n.state != ST_ERASE |=> (&s.flags) && !MAP_BUSY_OUT)
    else $error("erased map does not mark every sector");

  AST_PROG_START: assert property (
    s.state == ST_PROG_DATA && cs_rise |=> s.state == ST_PROGRAM ##1 MAP_BUSY_OUT)
    else $error("map program did not start busy");

  AST_FIRST_LOC: assert property (
    $changed(s.state) && s.state == ST_PROG_DATA |-> s.ptr == 5'h00)
    else $error("program data does not start at location 0");

  AST_WRAP: assert property (
    s.state == ST_PROG_DATA && ev && !cs_rise && s.ptr == 5'h1F |=> s.ptr == 5'h00)
    else $error("byte pointer did not wrap");

  AST_SUB0: assert property (
    map_we && map_waddr == 5'h00 |=>
      s.flags[0] == (&$past(map_wdata[7:6])) && s.flags[1] == (&$past(map_wdata[5:4])))
    else $error("byte 0 sub-sector decode wrong");

  AST_GATE_OFF: assert property (
    !PROT_EN_IN && s.wp_sync[1] |=> BLOCK_OUT == 33'h0)
    else $error("sector blocked without protection");

  AST_WP_BLOCKS: assert property (
    !s.wp_sync[1] |=> BLOCK_OUT == $past(s.flags))
    else $error("write-protect does not block marked sectors");

  AST_HIZ: assert property (
    CS_N_IN |-> !SO_OE_OUT && !PARALLEL_DATA_LINES_OE_OUT)
    else $error("outputs driven while deselected");

  AST_READ_STEP: assert property (
    s.state == ST_READ && ev && !cs_rise && nb_inc >= dummies + 4'h1
      |=> s.ptr == $past(s.ptr) + 5'h01)
    else $error("read pointer did not advance");

  AST_LATE_FRAME: assert property (
    s.busy && !n.busy && !s.cs_sync[2] |=> s.state == ST_IGNORE)
    else $error("frame open at end of busy was not ignored");

  AST_PROG_END: assert property (
    s.state == ST_PROGRAM && s.timer == 32'(PROGRAM_CYC - 1) |=> !MAP_BUSY_OUT)
    else $error("busy still set after the program time");

  COV_ERASE: cover property (s.state == ST_ERASE ##1 s.state == ST_IDLE);
  COV_PROGRAM: cover property (s.state == ST_PROGRAM ##1 s.state == ST_IDLE);
  COV_READ: cover property (s.state == ST_READ && s.ptr == 5'h02);
  COV_PAR_READ: cover property (s.state == ST_READ && lk.par_mode && s.ptr == 5'h02);
  COV_LATE_FRAME: cover property (s.busy && !n.busy && !s.cs_sync[2]);

endmodule
`default_nettype wire

// ==== verif/guard_host.sv ====
// Purpose: host model that frames commands on the serial link or the 8-bit port
// Assumes: link clock of 160 ns that stands low between frames
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module guard_host (
  // Pins toward the device
  output logic link_clk_out,
  output logic cs_n_out,
  output logic si_out,
  output logic port_sel_out,
  output logic [7:0] par_wire_out,
  // Pins driven by the device
  input wire logic so_in,
  input wire logic [7:0] par_d_in,
  input wire logic par_oe_in
);
  localparam time HALF = 80;
  logic [7:0] par_drv;
  // Wire level of the shared 8-bit port
  assign par_wire_out = par_oe_in ? par_d_in : par_drv;
  initial begin
    link_clk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    port_sel_out = 1'b0;
    par_drv = 8'h00;
  end
  task automatic open_frame(input logic psel);
    port_sel_out = psel;
    #HALF;
    cs_n_out = 1'b0;
    #HALF;
  endtask
  // Reply is sampled just before the rising edge that would move it on
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    if (port_sel_out) begin
      par_drv = tx;
      #HALF;
      rx = par_wire_out;
      link_clk_out = 1'b1;
      #HALF;
      link_clk_out = 1'b0;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        si_out = tx[i];
        #HALF;
        rx[i] = so_in;
        link_clk_out = 1'b1;
        #HALF;
        link_clk_out = 1'b0;
      end
    end
  endtask
  // Deselect one half period after the last falling edge, then idle the lines
  // Short tail so the caller still sees busy rise; open_frame keeps the gap
  task automatic close_frame();
    #HALF;
    cs_n_out = 1'b1;
    si_out = ~si_out;
    par_drv = ~par_drv;
    #(HALF / 4);
  endtask
endmodule
`default_nettype wire

// ==== verif/sector_guard_map_tb.sv ====
// Purpose: self-checking bench for the sector guard map commands
// Assumes: short timed cycles through the top parameters
// Notes: expected map kept in the bench; host tasks are called by path
`timescale 1ns/1ps
`default_nettype none
module sector_guard_map_tb;
  import guard_pkg::*;
  localparam int unsigned E_CYC = 150;
  localparam int unsigned P_CYC = 200;
  logic mclk, nrst, prot_en, wp_n;
  wire logic link_clk, cs_n, si, psel, so, so_oe, par_oe, busy;
  wire logic [7:0] par_wire, par_d;
  wire logic [FLAG_W-1:0] blk;
  logic [7:0] map_exp [MAP_BYTES];
  logic [7:0] rd [MAP_BYTES];
  int error_cnt, n_checks;

  sector_guard_map #(.ERASE_CYC(E_CYC), .PROGRAM_CYC(P_CYC)) uut (
    .MCLK_IN(mclk), .NRST_IN(nrst), .LINK_CLK_IN(link_clk), .CS_N_IN(cs_n),
    .SI_IN(si), .PORT_SEL_IN(psel), .PARALLEL_DATA_LINES_IN(par_wire),
    .SO_OUT(so), .SO_OE_OUT(so_oe), .PARALLEL_DATA_LINES_OUT(par_d),
    .PARALLEL_DATA_LINES_OE_OUT(par_oe), .PROT_EN_IN(prot_en), .WP_N_IN(wp_n),
    .MAP_BUSY_OUT(busy), .BLOCK_OUT(blk));
  guard_host host (
    .link_clk_out(link_clk), .cs_n_out(cs_n), .si_out(si), .port_sel_out(psel),
    .par_wire_out(par_wire), .so_in(so), .par_d_in(par_d), .par_oe_in(par_oe));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
      error_cnt++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmd4(input logic p, input logic [31:0] c);
    logic [7:0] r;
    host.open_frame(p);
    for (int i = 3; i >= 0; i--) host.xfer(c[8*i+:8], r);
    host.close_frame();
  endtask
  // Waits a bounded time for busy, then measures how long it stands
  task automatic timed_cycle(input logic run, input int unsigned len);
    int unsigned n;
    int w;
    w = 0;
    cycles(1);
    while (busy !== 1'b1 && w < 20) begin
      cycles(1);
      w++;
    end
    check("busy_start", busy === 1'b1, run);
    n = 0;
    while (busy === 1'b1 && n < len + 10) begin
      cycles(1);
      n++;
    end
    if (run) check("busy_len", n, len);
  endtask
  task automatic read_map(input logic p);
    logic [7:0] r;
    host.open_frame(p);
    host.xfer(CMD_MAP_READ, r);
    repeat (p ? 7 : 3) host.xfer(8'h00, r);
    for (int i = 0; i < MAP_BYTES; i++) host.xfer(8'h00, rd[i]);
    host.close_frame();
    check("so_oe_idle", so_oe, 1'b0);
    check("par_oe_idle", par_oe, 1'b0);
    for (int i = 0; i < MAP_BYTES; i++) check("map_byte", rd[i], map_exp[i]);
  endtask
  task automatic check_block();
    logic [FLAG_W-1:0] e;
    logic gate;
    gate = prot_en | ~wp_n;
    e[0] = (map_exp[0][SUB0A_HI:SUB0A_LO] == 2'b11) & gate;
    e[1] = (map_exp[0][SUB0B_HI:SUB0B_LO] == 2'b11) & gate;
    for (int k = 1; k < MAP_BYTES; k++) e[k+1] = (map_exp[k] == BYTE_ERASED) & gate;
    cycles(6);
    check("block", blk, e);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] r;
    error_cnt = 0;
    n_checks = 0;
    nrst = 1'b0;
    prot_en = 1'b0;
    wp_n = 1'b1;
    for (int i = 0; i < MAP_BYTES; i++) map_exp[i] = BYTE_SHIPPED;
    cycles(5);
    nrst = 1'b1;
    cycles(5);
    check("busy_reset", busy, 1'b0);
    check("block_reset", blk, '0);
    read_map(1'b0);
    // A command of another block must not start a timed cycle
    cmd4(1'b0, 32'h3D2A7FA9);
    timed_cycle(1'b0, 0);
    // Erase with protection on; every sector then blocked
    prot_en = 1'b1;
    cmd4(1'b0, CMD_MAP_ERASE);
    // A frame opened inside busy is dropped whole, also the bytes after busy ends
    fork
      timed_cycle(1'b1, E_CYC);
      begin
        host.open_frame(1'b0);
        host.xfer(8'h00, r);
        for (int i = 3; i >= 0; i--) host.xfer(CMD_MAP_ERASE[8*i+:8], r);
        host.close_frame();
      end
    join
    timed_cycle(1'b0, 0);
    for (int i = 0; i < MAP_BYTES; i++) map_exp[i] = BYTE_ERASED;
    check_block();
    read_map(1'b1);
    // Program 33 bytes: the last lands in location 0, only 00H or FFH elsewhere
    host.open_frame(1'b0);
    for (int i = 3; i >= 0; i--) host.xfer(CMD_MAP_PROGRAM[8*i+:8], r);
    host.xfer(8'hC0, r);
    for (int k = 1; k < MAP_BYTES; k++) begin
      map_exp[k] = (k % 3 == 0) ? BYTE_ERASED : BYTE_SHIPPED;
      host.xfer(map_exp[k], r);
    end
    host.xfer(8'h3F, r);
    map_exp[0] = 8'h3F;
    host.close_frame();
    // An erase sent during the busy time must be ignored
    fork
      timed_cycle(1'b1, P_CYC);
      begin
        cycles(30);
        cmd4(1'b1, CMD_MAP_ERASE);
      end
    join
    timed_cycle(1'b0, 0);
    check_block();
    read_map(1'b1);
    // Gating by the protection enable and the write-protect pin
    prot_en = 1'b0;
    check_block();
    wp_n = 1'b0;
    check_block();
    final_report();
  end

  initial begin
    #300000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
